/* common/arpt_defs.svh */
// Constants for the absolute rotary position tracker: offsets, fields, resets.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one register per word.
`ifndef ARPT_DEFS_SVH
`define ARPT_DEFS_SVH
`define ARPT_OFS_GEAR_NUM 8'h00
`define ARPT_OFS_GEAR_DEN 8'h04
`define ARPT_OFS_PULSES_LO 8'h08
`define ARPT_OFS_PULSES_HI 8'h0C
`define ARPT_OFS_DISP_LO 8'h10
`define ARPT_OFS_DISP_HI 8'h14
`define ARPT_OFS_MACH_LO 8'h18
`define ARPT_OFS_MACH_HI 8'h1C
`define ARPT_OFS_ENC_LO 8'h20
`define ARPT_OFS_ENC_HI 8'h24
`define ARPT_OFS_SINGLE 8'h28
`define ARPT_OFS_TURNS 8'h2C
`define ARPT_OFS_WITHIN 8'h30
`define ARPT_OFS_OVF_MASK 8'h34
`define ARPT_OFS_RST_CMD 8'h38
`define ARPT_OFS_CTRL 8'h3C
`define ARPT_OFS_EGEAR_A 8'h40
`define ARPT_OFS_EGEAR_B 8'h44
`define ARPT_OFS_LIM_MAX 8'h48
`define ARPT_OFS_LIM_MIN 8'h4C
`define ARPT_OFS_IRQ_STAT 8'h50
`define ARPT_OFS_IRQ_MASK 8'h54
`define ARPT_OFS_POS_CNT 8'h58
`define ARPT_RST_GEAR_NUM 16'hFFFF
`define ARPT_RST_GEAR_DEN 16'h0001
`define ARPT_RST_EGEAR 32'h0000_0001
`define ARPT_RST_LIM_MAX 32'h7FFF_FFFF
`define ARPT_RST_LIM_MIN 32'h8000_0000
`define ARPT_RES_SHIFT 23
`define ARPT_HI_BITS 7
`define ARPT_CTRL_MODE_LSB 0
`define ARPT_CTRL_SL_LSB 2
`define ARPT_IRQ_BATT_FAULT 0
`define ARPT_IRQ_BATT_WARN 1
`define ARPT_IRQ_OVERFLOW 2
`define ARPT_IRQ_LIM_POS 3
`define ARPT_IRQ_LIM_NEG 4
`define ARPT_IRQ_W 5
`endif

/* common/arpt_pkg.sv */
// Types shared by the absolute rotary position tracker.
// Assumes nothing of its surroundings.
package arpt_pkg;
    typedef enum logic [1:0] {
        ARPT_MODE_INCR = 2'h0,
        ARPT_MODE_LINEAR = 2'h1,
        ARPT_MODE_ROTARY = 2'h2
    } arpt_mode_t;
    typedef enum logic [1:0] {
        ARPT_SL_OFF = 2'h0,
        ARPT_SL_NOW = 2'h1,
        ARPT_SL_HOMED = 2'h2
    } arpt_sl_t;
    typedef enum logic [1:0] {
        ARPT_RST_NONE = 2'h0,
        ARPT_RST_FAULT = 2'h1,
        ARPT_RST_TURNS = 2'h2
    } arpt_rstcmd_t;
    typedef enum logic [1:0] {
        ARPT_BUS_IDLE = 2'h0,
        ARPT_BUS_ACK = 2'h1
    } arpt_bus_t;
endpackage : arpt_pkg

/* design/arpt_tracker.sv */
// Absolute rotary position tracker: per-load-rotation count, position
// conversion, encoder feedback display, faults, warnings and soft limit.
// Assumes a multi-turn encoder front end delivering turn count and in-turn
// position synchronous to clk, and an Avalon-MM master with waitrequest.
//
// Summary of operation
// - Low half or high half bits 6:0 nonzero: count is those 7 high bits shifted 32 plus low part.
// - Both halves zero: count is resolution times gear numerator over denominator.
// - Encoder single-turn resolution is 8388608 counts per motor revolution.
// - Command-unit position is encoder-unit position divided by gear ratio B over A.
// - Rotation mode has unlimited turns and never raises turn overflow fault.
// - Feedback is turn count plus in-turn position; incremental mode reports no turns.
// - Turn count in turns and in-turn position in encoder units are read-only.
// - Overflow mask 0 keeps the fault, 1 suppresses it, in linear mode.
// - First battery connection raises battery fault until a fault reset command.
// - Battery warning is raised while battery voltage is below three volts.
// - Battery replaced while powered and idle clears the warning by itself.
// - Battery swapped while unpowered raises battery fault; reset and re-home needed.
// - Soft limit compares position against limits, alarms and stops immediately.
// - Incremental mode needs the after-homing option; limit arms only after homing.
// - Rotation mode reports load position within one rotation in command units.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "arpt_defs.svh"
module arpt_tracker (
    input wire logic clk, // 100 MHz clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic enc_valid, // New encoder sample
    input wire logic [15:0] enc_turns, // Encoder turn count, signed
    input wire logic [22:0] enc_in_turn, // Encoder in-turn position
    input wire logic enc_batt_lost, // Encoder reports backup loss
    input wire logic batt_low, // Battery below 3.0 V
    input wire logic home_done, // Homing completed pulse
    output logic enc_clear_fault, // Pulse: clear encoder fault
    output logic enc_clear_turns, // Pulse: zero encoder turns
    output logic battery_fault, // Battery fault level
    output logic battery_low_warning, // Battery warning level
    output logic turn_overflow_fault, // Turn overflow fault level
    output logic motor_stop, // Soft limit stop request
    output logic irq // Level interrupt
);
    // Software-visible settings
    logic [15:0] gear_num_q, gear_den_q, pulses_hi_q, ovf_mask_q;
    logic [31:0] pulses_lo_q, egear_a_q, egear_b_q, lim_max_q, lim_min_q;
    logic [1:0] mode_q, sl_sel_q, rst_cmd_q;
    logic [`ARPT_IRQ_W-1:0] irq_stat_q, irq_mask_q;
    // Derived state
    logic signed [63:0] pe_q, pm_q, pos_cnt_q, single_q;
    logic [63:0] rm_q;
    logic [15:0] turns_q, prev_turns_q;
    logic [22:0] in_turn_q;
    logic batt_fault_q, ovf_q, homed_q, lim_pos_q, lim_neg_q, warn_q, lost_q;
    logic cmd_fault_q, cmd_turns_q;
    arpt_pkg::arpt_bus_t bus_q;

    // Bus decode: one wait state, then answer
    wire req = avs_read | avs_write;
    wire take = req & (bus_q == arpt_pkg::ARPT_BUS_IDLE);
    wire wr = take & avs_write & (avs_byteenable == 4'hF);
    wire rd = take & avs_read;
    assign avs_waitrequest = req & (bus_q != arpt_pkg::ARPT_BUS_ACK);

    // Per-load-rotation count selection
    wire pulses_set = (pulses_lo_q != 32'h0) | (pulses_hi_q[`ARPT_HI_BITS-1:0] != 7'h0);
    wire [15:0] den_safe = (gear_den_q == 16'h0) ? 16'h1 : gear_den_q;
    wire [63:0] rm_direct = {25'h0, pulses_hi_q[`ARPT_HI_BITS-1:0], pulses_lo_q};
    wire [63:0] rm_scaled = {25'h0, gear_num_q, 23'h0};
    wire [63:0] rm_gear = rm_scaled / {48'h0, den_safe};
    wire [63:0] rm_d = pulses_set ? rm_direct : rm_gear;
    wire [63:0] rm_safe = (rm_q == 64'h0) ? 64'h1 : rm_q;

    // Encoder position and command-unit conversion
    wire [15:0] turns_eff = (mode_q == arpt_pkg::ARPT_MODE_INCR) ? 16'h0 : enc_turns;
    wire signed [63:0] pe_d = $signed({{25{turns_eff[15]}}, turns_eff, enc_in_turn});
    wire signed [63:0] ga = $signed({32'h0, (egear_a_q == 32'h0) ? 32'h1 : egear_a_q});
    wire signed [63:0] gb = $signed({32'h0, (egear_b_q == 32'h0) ? 32'h1 : egear_b_q});
    wire signed [63:0] pos_cnt_d = (pm_q * ga) / gb;
    wire signed [63:0] rem = pm_q % $signed(rm_safe);
    wire signed [63:0] rem_pos = rem[63] ? rem + $signed(rm_safe) : rem;
    wire signed [63:0] single_d = (rem_pos * ga) / gb;

    // Turn overflow detection, linear mode only
    wire wrap = enc_valid & (((prev_turns_q == 16'h7FFF) & (enc_turns == 16'h8000)) |
                ((prev_turns_q == 16'h8000) & (enc_turns == 16'h7FFF)));
    wire ovf_evt = wrap & (mode_q == arpt_pkg::ARPT_MODE_LINEAR) & ~ovf_mask_q[0];

    // Soft limit arming and comparison
    wire signed [31:0] lmax = $signed(lim_max_q) < $signed(lim_min_q) ? lim_min_q : lim_max_q;
    wire signed [31:0] lmin = $signed(lim_max_q) < $signed(lim_min_q) ? lim_max_q : lim_min_q;
    wire sl_now = (sl_sel_q == arpt_pkg::ARPT_SL_NOW) & (mode_q != arpt_pkg::ARPT_MODE_INCR);
    wire sl_armed = sl_now | ((sl_sel_q != arpt_pkg::ARPT_SL_OFF) & homed_q);
    wire signed [31:0] pc32 = pos_cnt_q[31:0];
    wire lim_pos_d = sl_armed & (pc32 > lmax);
    wire lim_neg_d = sl_armed & (pc32 < lmin);

    // Reset command decode
    wire cmd_wr = wr & (avs_address == `ARPT_OFS_RST_CMD);
    wire cmd_fault = cmd_wr & ((avs_writedata[1:0] == arpt_pkg::ARPT_RST_FAULT) |
                     (avs_writedata[1:0] == arpt_pkg::ARPT_RST_TURNS));
    wire cmd_turns = cmd_wr & (avs_writedata[1:0] == arpt_pkg::ARPT_RST_TURNS);

    // Interrupt events and write-one-to-clear
    wire batt_evt = enc_batt_lost & ~lost_q;
    wire warn_evt = batt_low & ~warn_q;
    wire [`ARPT_IRQ_W-1:0] evt = {lim_neg_d & ~lim_neg_q, lim_pos_d & ~lim_pos_q, ovf_evt, warn_evt, batt_evt};
    wire stat_wr = wr & (avs_address == `ARPT_OFS_IRQ_STAT);
    wire [`ARPT_IRQ_W-1:0] w1c = stat_wr ? avs_writedata[`ARPT_IRQ_W-1:0] : 5'h0;
    wire [`ARPT_IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~w1c) | evt;

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        case (avs_address)
            `ARPT_OFS_GEAR_NUM: rdata = {16'h0, gear_num_q};
            `ARPT_OFS_GEAR_DEN: rdata = {16'h0, gear_den_q};
            `ARPT_OFS_PULSES_LO: rdata = pulses_lo_q;
            `ARPT_OFS_PULSES_HI: rdata = {16'h0, pulses_hi_q};
            `ARPT_OFS_DISP_LO: rdata = rm_q[31:0];
            `ARPT_OFS_DISP_HI: rdata = rm_q[63:32];
            `ARPT_OFS_MACH_LO: rdata = pm_q[31:0];
            `ARPT_OFS_MACH_HI: rdata = pm_q[63:32];
            `ARPT_OFS_ENC_LO: rdata = pe_q[31:0];
            `ARPT_OFS_ENC_HI: rdata = pe_q[63:32];
            `ARPT_OFS_SINGLE: rdata = single_q[31:0];
            `ARPT_OFS_TURNS: rdata = {16'h0, turns_q};
            `ARPT_OFS_WITHIN: rdata = {9'h0, in_turn_q};
            `ARPT_OFS_OVF_MASK: rdata = {16'h0, ovf_mask_q};
            `ARPT_OFS_RST_CMD: rdata = {30'h0, rst_cmd_q};
            `ARPT_OFS_CTRL: rdata = {28'h0, sl_sel_q, mode_q};
            `ARPT_OFS_EGEAR_A: rdata = egear_a_q;
            `ARPT_OFS_EGEAR_B: rdata = egear_b_q;
            `ARPT_OFS_LIM_MAX: rdata = lim_max_q;
            `ARPT_OFS_LIM_MIN: rdata = lim_min_q;
            `ARPT_OFS_IRQ_STAT: rdata = {27'h0, irq_stat_q};
            `ARPT_OFS_IRQ_MASK: rdata = {27'h0, irq_mask_q};
            `ARPT_OFS_POS_CNT: rdata = pos_cnt_q[31:0];
            default: rdata = 32'h0;
        endcase
    end

    // Bus handshake state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_q <= arpt_pkg::ARPT_BUS_IDLE;
            avs_readdata <= 32'h0;
        end else begin
            case (bus_q)
                arpt_pkg::ARPT_BUS_IDLE: bus_q <= take ? arpt_pkg::ARPT_BUS_ACK : arpt_pkg::ARPT_BUS_IDLE;
                arpt_pkg::ARPT_BUS_ACK: bus_q <= arpt_pkg::ARPT_BUS_IDLE;
                default: bus_q <= arpt_pkg::ARPT_BUS_IDLE;
            endcase
            if (rd) begin
                avs_readdata <= rdata;
            end
        end
    end

    // Writable settings
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gear_num_q <= `ARPT_RST_GEAR_NUM;
            gear_den_q <= `ARPT_RST_GEAR_DEN;
            pulses_lo_q <= 32'h0;
            pulses_hi_q <= 16'h0;
            ovf_mask_q <= 16'h0;
            mode_q <= arpt_pkg::ARPT_MODE_INCR;
            sl_sel_q <= arpt_pkg::ARPT_SL_OFF;
            egear_a_q <= `ARPT_RST_EGEAR;
            egear_b_q <= `ARPT_RST_EGEAR;
            lim_max_q <= `ARPT_RST_LIM_MAX;
            lim_min_q <= `ARPT_RST_LIM_MIN;
            irq_mask_q <= 5'h0;
        end else if (wr) begin
            case (avs_address)
                `ARPT_OFS_GEAR_NUM: gear_num_q <= avs_writedata[15:0];
                `ARPT_OFS_GEAR_DEN: gear_den_q <= avs_writedata[15:0];
                `ARPT_OFS_PULSES_LO: pulses_lo_q <= avs_writedata;
                `ARPT_OFS_PULSES_HI: pulses_hi_q <= avs_writedata[15:0];
                `ARPT_OFS_OVF_MASK: ovf_mask_q <= avs_writedata[15:0];
                `ARPT_OFS_CTRL: begin
                    mode_q <= avs_writedata[`ARPT_CTRL_MODE_LSB +: 2];
                    sl_sel_q <= avs_writedata[`ARPT_CTRL_SL_LSB +: 2];
                end
                `ARPT_OFS_EGEAR_A: egear_a_q <= avs_writedata;
                `ARPT_OFS_EGEAR_B: egear_b_q <= avs_writedata;
                `ARPT_OFS_LIM_MAX: lim_max_q <= avs_writedata;
                `ARPT_OFS_LIM_MIN: lim_min_q <= avs_writedata;
                `ARPT_OFS_IRQ_MASK: irq_mask_q <= avs_writedata[`ARPT_IRQ_W-1:0];
                default: irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // Position pipeline: count, encoder, machine, converted values
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rm_q <= 64'h0;
            pe_q <= 64'sh0;
            pm_q <= 64'sh0;
            pos_cnt_q <= 64'sh0;
            single_q <= 64'sh0;
            turns_q <= 16'h0;
            prev_turns_q <= 16'h0;
            in_turn_q <= 23'h0;
        end else begin
            rm_q <= rm_d;
            if (enc_valid) begin
                pe_q <= pe_d;
                turns_q <= turns_eff;
                in_turn_q <= enc_in_turn;
                prev_turns_q <= enc_turns;
            end
            pm_q <= pe_q;
            pos_cnt_q <= pos_cnt_d;
            single_q <= single_d;
        end
    end

    // Fault, warning, homing and command flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            batt_fault_q <= 1'b0;
            lost_q <= 1'b0;
            warn_q <= 1'b0;
            ovf_q <= 1'b0;
            homed_q <= 1'b0;
            lim_pos_q <= 1'b0;
            lim_neg_q <= 1'b0;
            rst_cmd_q <= 2'h0;
            cmd_fault_q <= 1'b0;
            cmd_turns_q <= 1'b0;
            irq_stat_q <= 5'h0;
        end else begin
            lost_q <= enc_batt_lost;
            batt_fault_q <= batt_evt | (batt_fault_q & ~cmd_fault);
            warn_q <= batt_low;
            ovf_q <= ovf_evt | (ovf_q & ~cmd_fault & (mode_q == arpt_pkg::ARPT_MODE_LINEAR));
            homed_q <= home_done | (homed_q & ~cmd_turns);
            lim_pos_q <= lim_pos_d;
            lim_neg_q <= lim_neg_d;
            rst_cmd_q <= cmd_wr ? avs_writedata[1:0] : arpt_pkg::ARPT_RST_NONE;
            cmd_fault_q <= cmd_fault;
            cmd_turns_q <= cmd_turns;
            irq_stat_q <= irq_stat_d;
        end
    end

    // Outputs
    assign enc_clear_fault = cmd_fault_q;
    assign enc_clear_turns = cmd_turns_q;
    assign battery_fault = batt_fault_q;
    assign battery_low_warning = warn_q;
    assign turn_overflow_fault = ovf_q;
    assign motor_stop = lim_pos_q | lim_neg_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    // Checks
    property p_direct_count;
        @(posedge clk) disable iff (!rstn)
        pulses_set |=> rm_q == {25'h0, $past(pulses_hi_q[6:0]), $past(pulses_lo_q)};
    endproperty
    a_direct_count: assert property (p_direct_count) else $error("direct count wrong");
    property p_gear_count;
        @(posedge clk) disable iff (!rstn)
        (!pulses_set && gear_den_q == 16'h1) |=> rm_q == {25'h0, $past(gear_num_q), 23'h0};
    endproperty
    a_gear_count: assert property (p_gear_count) else $error("gear count wrong");
    property p_resolution;
        @(posedge clk) disable iff (!rstn)
        (enc_valid && mode_q == arpt_pkg::ARPT_MODE_ROTARY && enc_turns == 16'h1 && enc_in_turn == 23'h0)
        |=> pe_q == 64'sd8388608;
    endproperty
    a_resolution: assert property (p_resolution) else $error("resolution not 8388608");
    property p_unit_gear;
        @(posedge clk) disable iff (!rstn)
        (egear_a_q == 32'h1 && egear_b_q == 32'h1 && $stable(egear_a_q) && $stable(egear_b_q))
        |=> pos_cnt_q == $past(pm_q);
    endproperty
    a_unit_gear: assert property (p_unit_gear) else $error("position counter not pm");
    property p_no_ovf_rotary;
        @(posedge clk) disable iff (!rstn)
        mode_q == arpt_pkg::ARPT_MODE_ROTARY |=> !turn_overflow_fault;
    endproperty
    a_no_ovf_rotary: assert property (p_no_ovf_rotary) else $error("overflow in rotary mode");
    property p_incr_turns;
        @(posedge clk) disable iff (!rstn)
        (enc_valid && mode_q == arpt_pkg::ARPT_MODE_INCR) |=> turns_q == 16'h0;
    endproperty
    a_incr_turns: assert property (p_incr_turns) else $error("turns shown in incremental mode");
    property p_mask;
        @(posedge clk) disable iff (!rstn)
        (ovf_mask_q[0] && !turn_overflow_fault) |=> !turn_overflow_fault;
    endproperty
    a_mask: assert property (p_mask) else $error("masked overflow raised");
    property p_reset_cmd;
        @(posedge clk) disable iff (!rstn)
        cmd_turns |=> enc_clear_turns && enc_clear_fault ##1 !enc_clear_turns;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("turn reset pulse wrong");
    property p_batt_fault;
        @(posedge clk) disable iff (!rstn)
        (enc_batt_lost && !$past(enc_batt_lost)) |=> battery_fault;
    endproperty
    a_batt_fault: assert property (p_batt_fault) else $error("battery fault missed");
    property p_warn;
        @(posedge clk) disable iff (!rstn)
        batt_low |=> battery_low_warning;
    endproperty
    a_warn: assert property (p_warn) else $error("battery warning missed");
    property p_warn_clear;
        @(posedge clk) disable iff (!rstn)
        !batt_low |=> !battery_low_warning;
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("battery warning stuck");
    property p_limit;
        @(posedge clk) disable iff (!rstn)
        (sl_armed && pc32 > lmax) |=> motor_stop;
    endproperty
    a_limit: assert property (p_limit) else $error("soft limit missed");
    property p_unarmed;
        @(posedge clk) disable iff (!rstn)
        (mode_q == arpt_pkg::ARPT_MODE_INCR && !homed_q) |=> !motor_stop;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("limit armed before homing");
    property p_single_range;
        @(posedge clk) disable iff (!rstn)
        (egear_a_q == 32'h1 && egear_b_q == 32'h1 && $stable(egear_a_q) && $stable(egear_b_q) && rm_q != 64'h0)
        |=> (single_q >= 0) && ($unsigned(single_q) < $past(rm_q));
    endproperty
    a_single_range: assert property (p_single_range) else $error("single turn out of range");
endmodule : arpt_tracker

/* tb/arpt_enc_model.sv */
// Behavioural multi-turn encoder facing the tracker's encoder port.
// Assumes the bench chooses positions; the sample strobe stays high after reset.
`timescale 1ns/1ps
module arpt_enc_model (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [15:0] set_turns, // Turns chosen by the bench
    input wire logic [22:0] set_pos, // In-turn position chosen by the bench
    input wire logic set_load, // Load the chosen position
    input wire logic swap_unpowered, // Battery swapped while unpowered
    input wire logic enc_clear_fault, // Clear fault pulse
    input wire logic enc_clear_turns, // Zero turns pulse
    output logic enc_valid, // Sample strobe
    output logic [15:0] enc_turns, // Turn count
    output logic [22:0] enc_in_turn, // In-turn position
    output logic enc_batt_lost // Backup lost flag
);
    logic first_q; // First cycle with a fresh battery
    // Position store and backup loss latch
    always_ff @(posedge clk) begin
        if (!rstn) begin
            enc_valid <= 1'b0;
            enc_turns <= 16'h0000;
            enc_in_turn <= 23'h000000;
            enc_batt_lost <= 1'b0;
            first_q <= 1'b1;
        end else begin
            enc_valid <= 1'b1;
            first_q <= 1'b0;
            if (set_load) begin
                enc_turns <= set_turns;
                enc_in_turn <= set_pos;
            end else if (enc_clear_turns) begin
                enc_turns <= 16'h0000;
            end
            if (first_q || swap_unpowered) begin
                enc_batt_lost <= 1'b1;
            end else if (enc_clear_fault) begin
                enc_batt_lost <= 1'b0;
            end
        end
    end
endmodule : arpt_enc_model

/* tb/tb_absolute_rotary_position_tracker.sv */
// Self-checking bench for the rotary position tracker over its register bus.
// Assumes the encoder model on the far side and a 100 MHz clock.
`timescale 1ns/1ps
`include "arpt_defs.svh"
module tb_absolute_rotary_position_tracker;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, enc_valid, enc_batt_lost, batt_low, home_done;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [15:0] enc_turns, set_turns;
    logic [22:0] enc_in_turn, set_pos;
    logic enc_clear_fault, enc_clear_turns, battery_fault, battery_low_warning, turn_overflow_fault;
    logic motor_stop, irq, set_load, swap_unpowered;
    int fail_count, checks, cycles, n_cf, n_ct;
    logic [31:0] ovf_mode [3] = '{32'h2, 32'h1, 32'h1};
    logic [31:0] ovf_mask [3] = '{32'h0, 32'h1, 32'h0};
    logic ovf_exp [3] = '{1'b0, 1'b0, 1'b1};
    arpt_tracker dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enc_valid(enc_valid),
        .enc_turns(enc_turns), .enc_in_turn(enc_in_turn), .enc_batt_lost(enc_batt_lost), .batt_low(batt_low),
        .home_done(home_done), .enc_clear_fault(enc_clear_fault), .enc_clear_turns(enc_clear_turns),
        .battery_fault(battery_fault), .battery_low_warning(battery_low_warning),
        .turn_overflow_fault(turn_overflow_fault), .motor_stop(motor_stop), .irq(irq));
    arpt_enc_model enc_m (.clk(clk), .rstn(rstn), .set_turns(set_turns), .set_pos(set_pos), .set_load(set_load),
        .swap_unpowered(swap_unpowered), .enc_clear_fault(enc_clear_fault), .enc_clear_turns(enc_clear_turns),
        .enc_valid(enc_valid), .enc_turns(enc_turns), .enc_in_turn(enc_in_turn), .enc_batt_lost(enc_batt_lost));
    // Clock
    always #5 clk = ~clk;
    // Pulse counting and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (enc_clear_fault === 1'b1) n_cf <= n_cf + 1;
        if (enc_clear_turns === 1'b1) n_ct <= n_ct + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task chkb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chkb
    // One bus access, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr
    task rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rd, e);
    endtask : rc
    task rc2(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        rc(a, lo);
        rc(a + 8'h04, hi);
    endtask : rc2
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task enc(input logic [15:0] t, input logic [22:0] p);
        @(posedge clk);
        set_turns <= t;
        set_pos <= p;
        set_load <= 1'b1;
        @(posedge clk);
        set_load <= 1'b0;
        tick(6);
    endtask : enc
    task pulse_home;
        @(posedge clk);
        home_done <= 1'b1;
        @(posedge clk);
        home_done <= 1'b0;
        tick(6);
    endtask : pulse_home
    // Main sequence
    initial begin
        clk = 1'b0; rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
        avs_writedata = 32'h0; avs_byteenable = 4'hF; batt_low = 1'b0; home_done = 1'b0;
        set_turns = 16'h0000; set_pos = 23'h000000; set_load = 1'b0; swap_unpowered = 1'b0;
        fail_count = 0; checks = 0; cycles = 0; n_cf = 0; n_ct = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        tick(4);
        chkb(battery_fault, 1'b1);
        rc(`ARPT_OFS_GEAR_NUM, 32'h0000FFFF);
        rc(`ARPT_OFS_GEAR_DEN, 32'h00000001);
        rc2(`ARPT_OFS_PULSES_LO, 32'h0, 32'h0);
        rc(`ARPT_OFS_OVF_MASK, 32'h0);
        wr(8'hFC, 32'h12345678);
        rc(8'hFC, 32'h0);
        bus(1'b1, `ARPT_OFS_GEAR_NUM, 32'h5, 4'h3);
        rc(`ARPT_OFS_GEAR_NUM, 32'h0000FFFF);
        $display("test reset_values done");
        wr(`ARPT_OFS_IRQ_MASK, 32'h1);
        tick(2);
        chkb(irq, 1'b1);
        wr(`ARPT_OFS_RST_CMD, 32'h1);
        tick(2);
        chkb(battery_fault, 1'b0);
        chkb(irq, 1'b1);
        wr(`ARPT_OFS_IRQ_STAT, 32'h1);
        tick(2);
        chkb(irq, 1'b0);
        chk(n_cf, 1);
        chk(n_ct, 0);
        $display("test first_battery done");
        rc2(`ARPT_OFS_DISP_LO, 32'hFF800000, 32'h7F);
        wr(`ARPT_OFS_GEAR_NUM, 32'h3);
        wr(`ARPT_OFS_GEAR_DEN, 32'h2);
        tick(4);
        rc2(`ARPT_OFS_DISP_LO, 32'h00C00000, 32'h0);
        wr(`ARPT_OFS_PULSES_HI, 32'h1);
        tick(4);
        rc2(`ARPT_OFS_DISP_LO, 32'h0, 32'h1);
        wr(`ARPT_OFS_PULSES_HI, 32'h0);
        wr(`ARPT_OFS_PULSES_LO, 32'h01000000);
        tick(4);
        rc2(`ARPT_OFS_DISP_LO, 32'h01000000, 32'h0);
        $display("test rotation_count done");
        enc(16'h0003, 23'h000100);
        rc(`ARPT_OFS_TURNS, 32'h0);
        rc(`ARPT_OFS_WITHIN, 32'h100);
        wr(`ARPT_OFS_CTRL, 32'h2);
        tick(4);
        rc(`ARPT_OFS_TURNS, 32'h3);
        wr(`ARPT_OFS_TURNS, 32'h55);
        rc(`ARPT_OFS_TURNS, 32'h3);
        rc2(`ARPT_OFS_ENC_LO, 32'h01800100, 32'h0);
        rc2(`ARPT_OFS_MACH_LO, 32'h01800100, 32'h0);
        rc(`ARPT_OFS_SINGLE, 32'h00800100);
        wr(`ARPT_OFS_EGEAR_B, 32'h2);
        tick(5);
        rc(`ARPT_OFS_POS_CNT, 32'h00C00080);
        rc(`ARPT_OFS_SINGLE, 32'h00400080);
        enc(16'hFFFF, 23'h000000);
        rc2(`ARPT_OFS_ENC_LO, 32'hFF800000, 32'hFFFFFFFF);
        rc(`ARPT_OFS_SINGLE, 32'h00400000);
        $display("test position done");
        for (int i = 0; i < 3; i++) begin
            wr(`ARPT_OFS_CTRL, ovf_mode[i]);
            wr(`ARPT_OFS_OVF_MASK, ovf_mask[i]);
            enc(16'h7FFF, 23'h000000);
            enc(16'h8000, 23'h000000);
            chkb(turn_overflow_fault, ovf_exp[i]);
            wr(`ARPT_OFS_RST_CMD, 32'h1);
            tick(2);
            chkb(turn_overflow_fault, 1'b0);
        end
        bus(1'b0, `ARPT_OFS_IRQ_STAT, 32'h0, 4'hF);
        chk(rd & 32'h4, 32'h4);
        $display("test overflow done");
        wr(`ARPT_OFS_OVF_MASK, 32'h0);
        wr(`ARPT_OFS_EGEAR_B, 32'h1);
        wr(`ARPT_OFS_LIM_MAX, 32'h100);
        wr(`ARPT_OFS_CTRL, 32'h8);
        enc(16'h0000, 23'h000200);
        chkb(motor_stop, 1'b0);
        pulse_home();
        chkb(motor_stop, 1'b1);
        $display("test soft_limit done");
        wr(`ARPT_OFS_CTRL, 32'h2);
        enc(16'h0001, 23'h000000);
        @(posedge clk);
        swap_unpowered <= 1'b1;
        @(posedge clk);
        swap_unpowered <= 1'b0;
        tick(4);
        chkb(battery_fault, 1'b1);
        wr(`ARPT_OFS_RST_CMD, 32'h2);
        tick(2);
        chkb(battery_fault, 1'b0);
        rc(`ARPT_OFS_RST_CMD, 32'h0);
        tick(4);
        rc(`ARPT_OFS_TURNS, 32'h0);
        chk(n_ct, 1);
        chk(n_cf, 5);
        wr(`ARPT_OFS_CTRL, 32'h6);
        wr(`ARPT_OFS_LIM_MIN, 32'h10);
        tick(5);
        chkb(motor_stop, 1'b1);
        pulse_home();
        $display("test battery_swap done");
        batt_low <= 1'b1;
        tick(3);
        chkb(battery_low_warning, 1'b1);
        batt_low <= 1'b0;
        tick(3);
        chkb(battery_low_warning, 1'b0);
        $display("test battery_warning done");
        report_and_stop();
    end
endmodule : tb_absolute_rotary_position_tracker
